// *** bbp_pkg.sv ***
// constants, encodings and database map for the backplane block pager
//
// Overview of operation
// R01 - output image: index word 0, payload 1..200
// R02 - received index selects database store location
// R03 - input image: reserved, write request, 200 read words
// R04 - trailer: scan counter, identity words, port errors
// R05 - transfer status, last errors, read index 249
// R06 - trailer refreshed in every normal input image
// R07 - read and write indices step, wrap independently
// R08 - out-of-sequence index or requests break sequence
// R09 - after restart, request configuration one index each
// R10 - configuration image index 9000 with setup fields
// R11 - configuration request: 9000, error words, minus two
// R12 - fault bits set; no normal operation while faulty
// R13 - fetch command lists 6000..6003 and 6100..6103
// R14 - command blocks of 25 definitions, requested in order
// R15 - host answers every requested write index
// R16 - normal paging only touches user words 0..4999; code also reads 5200..5238, and 5000..5008 at read index 24
// R17 - input image 250 words, output image 248
// R18 - index times 200 is base, larger rejected
package bbp_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned DB_AW  = 13;

  // image word positions
  localparam logic [7:0] IN_LAST      = 8'hf9;
  localparam logic [7:0] OUT_LAST     = 8'hf7;
  localparam logic [7:0] W_RSV        = 8'h00;
  localparam logic [7:0] W_REQ        = 8'h01;
  localparam logic [7:0] W_RD_FIRST   = 8'h02;
  localparam logic [7:0] W_RD_LAST    = 8'hc9;
  localparam logic [7:0] W_SCAN       = 8'hca;
  localparam logic [7:0] W_ID_FIRST   = 8'hcb;
  localparam logic [7:0] W_PERR_FIRST = 8'hd3;
  localparam logic [7:0] W_PERR_LAST  = 8'he0;
  localparam logic [7:0] W_XFER_FIRST = 8'he1;
  localparam logic [7:0] W_XFER_LAST  = 8'he6;
  localparam logic [7:0] W_LERR_FIRST = 8'he7;
  localparam logic [7:0] W_LERR_LAST  = 8'hea;
  localparam logic [7:0] W_CFG_MOD    = 8'h02;
  localparam logic [7:0] W_CFG_P1     = 8'h03;
  localparam logic [7:0] W_CFG_P2     = 8'h04;
  localparam logic [7:0] O_ID         = 8'h00;
  localparam logic [7:0] O_PAY_FIRST  = 8'h01;
  localparam logic [7:0] O_PAY_LAST   = 8'hc8;
  localparam logic [7:0] O_CFG_RCNT   = 8'h01;
  localparam logic [7:0] O_CFG_WCNT   = 8'h02;
  localparam logic [7:0] O_CFG_P1_TYP = 8'h07;
  localparam logic [7:0] O_CFG_P2_TYP = 8'h20;

  // block indices and tags
  localparam logic [15:0] CFG_ID     = 16'h2328;
  localparam logic [15:0] CMD_ID_P1  = 16'h1770;
  localparam logic [15:0] CMD_ID_P2  = 16'h17d4;
  localparam logic [15:0] CFG_TAG    = 16'hfffe;
  localparam logic [15:0] CMD_TAG    = 16'hfffd;
  localparam logic [15:0] MAX_INDEX  = 16'h0018;
  localparam logic [15:0] PORT_TYPE_MAX = 16'h0002;
  localparam logic [2:0]  CMD_BLK_LAST  = 3'h7;
  localparam logic [4:0]  FIRST_INDEX   = 5'h01;

  // database map
  localparam logic [12:0] BLOCK_WORDS  = 13'h00c8;
  localparam logic [12:0] DB_CFG_BASE  = 13'h1388;
  localparam logic [12:0] DB_STAT_BASE = 13'h1450;
  localparam logic [12:0] DB_CMD_P1    = 13'h1518;
  localparam logic [12:0] DB_CMD_P2    = 13'h1838;

  // configuration fault bits
  localparam int unsigned ERR_RCNT  = 0;
  localparam int unsigned ERR_WCNT  = 1;
  localparam int unsigned ERR_PTYPE = 0;

  // transfer status counters, words 225..230
  localparam int unsigned XF_RD   = 0;
  localparam int unsigned XF_WR   = 1;
  localparam int unsigned XF_OOS  = 2;
  localparam int unsigned XF_REJ  = 3;
  localparam int unsigned XF_CFG  = 4;
  localparam int unsigned XF_CMD  = 5;
  localparam int unsigned XF_N    = 6;

  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_WAIT = 2'h1;
  localparam logic [1:0] PH_PUSH = 2'h2;

  typedef enum logic [1:0] {
    ST_SEND = 2'b00,
    ST_RECV = 2'b01,
    ST_HOLD = 2'b10
  } bbp_state_t;

  typedef enum logic [1:0] {
    MODE_CFG  = 2'b00,
    MODE_CMD  = 2'b01,
    MODE_NORM = 2'b10
  } bbp_mode_t;

endpackage : bbp_pkg

// *** bbp_fifo.sv ***
// small fifo with valid/ready on both sides
`timescale 1ns/100ps
module bbp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic      [WIDTH-1:0] o_rd_data
);

  localparam int unsigned AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
  logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push;
  logic             pop;

  assign o_wr_ready = (cnt_q != CNT_FULL);
  assign o_rd_valid = (cnt_q != '0);
  assign o_rd_data  = mem_q[rd_ptr_q];
  assign push       = i_wr_valid & o_wr_ready;
  assign pop        = o_rd_valid & i_rd_ready;

  always_comb begin
    mem_d    = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d    = cnt_q;
    if (push) begin
      mem_d[wr_ptr_q] = i_wr_data;
      wr_ptr_d = (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      mem_q    <= mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
    end
  end

endmodule : bbp_fifo

// *** bbp_pager.sv ***
// backplane block pager: pages the word database through the host images
`timescale 1ns/100ps
module bbp_pager #(
  // identity words; values are arbitrary
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0001,
  parameter logic [31:0] PRODUCT_VER  = 32'h0000_0001,
  parameter logic [31:0] OS_CODE      = 32'h0000_0001,
  parameter logic [31:0] RUN_NUMBER   = 32'h0000_0001,
  parameter int unsigned FIFO_DEPTH   = 2
) (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_restart,
  input  wire logic                         i_net_cmd_req,
  input  wire logic                         i_dbg_req,
  input  wire logic                         i_out_valid,
  output logic                              o_out_ready,
  input  wire logic [bbp_pkg::WORD_W-1:0]   i_out_data,
  output logic                              o_in_valid,
  input  wire logic                         i_in_ready,
  output logic      [bbp_pkg::WORD_W-1:0]   o_in_data,
  output logic      [bbp_pkg::DB_AW-1:0]    o_db_addr,
  output logic                              o_db_we,
  output logic      [bbp_pkg::WORD_W-1:0]   o_db_wdata,
  input  wire logic [bbp_pkg::WORD_W-1:0]   i_db_rdata,
  output logic      [1:0]                   o_mode,
  output logic                              o_cfg_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // state

  bbp_pkg::bbp_state_t state_q, state_d;
  bbp_pkg::bbp_mode_t  mode_q, mode_d;
  logic [7:0]                  k_q, k_d;
  logic [1:0]                  ph_q, ph_d;
  logic [4:0]                  rd_idx_q, rd_idx_d;
  logic [4:0]                  wr_idx_q, wr_idx_d;
  logic [4:0]                  nrd_q, nrd_d;
  logic [4:0]                  nwr_q, nwr_d;
  logic [2:0]                  blk_q, blk_d;
  logic [15:0]                 rx_id_q, rx_id_d;
  logic                        rx_ok_q, rx_ok_d;
  logic [15:0]                 err_mod_q, err_mod_d;
  logic [15:0]                 err_p1_q, err_p1_d;
  logic [15:0]                 err_p2_q, err_p2_d;
  logic [15:0]                 scan_q, scan_d;
  logic [15:0]                 xfer_q [bbp_pkg::XF_N];
  logic [15:0]                 xfer_d [bbp_pkg::XF_N];
  logic                        rst_pend_q, rst_pend_d;
  logic [12:0]                 db_addr_q, db_addr_d;
  logic                        db_we_q, db_we_d;
  logic [15:0]                 db_wdata_q, db_wdata_d;

  logic        push_valid;
  logic        push_ready;
  logic [15:0] push_data;
  logic [15:0] req_id;
  logic [12:0] rd_base;
  logic [12:0] rx_base;
  logic        take_restart;

  assign o_out_ready = (state_q == bbp_pkg::ST_RECV);
  assign o_db_addr   = db_addr_q;
  assign o_db_we     = db_we_q;
  assign o_db_wdata  = db_wdata_q;
  assign o_mode      = mode_q;
  assign o_cfg_fault = (err_mod_q | err_p1_q | err_p2_q) != 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // requested index, database bases

  always_comb begin
    case (mode_q)
      bbp_pkg::MODE_CFG:  req_id = bbp_pkg::CFG_ID;                        // see R11
      bbp_pkg::MODE_CMD:  req_id = (blk_q[2] ? bbp_pkg::CMD_ID_P2 : bbp_pkg::CMD_ID_P1)
                                   + 16'(blk_q[1:0]);                      // see R13
      default:            req_id = 16'(wr_idx_q);
    endcase
  end

  // index times block size; indices stop at 24 so 4999 is the top read word, 5008 the top address
  assign rd_base = 13'(rd_idx_q) * bbp_pkg::BLOCK_WORDS;                   // see R18

  always_comb begin
    case (mode_q)
      bbp_pkg::MODE_CFG: rx_base = bbp_pkg::DB_CFG_BASE;
      bbp_pkg::MODE_CMD: rx_base = (blk_q[2] ? bbp_pkg::DB_CMD_P2 : bbp_pkg::DB_CMD_P1)
                                   + 13'(blk_q[1:0]) * bbp_pkg::BLOCK_WORDS; // see R14
      default:           rx_base = 13'(rx_id_q[4:0]) * bbp_pkg::BLOCK_WORDS; // see R02
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // input image word selection

  always_comb begin
    push_data = 16'h0000;
    if (k_q == bbp_pkg::W_REQ) begin
      push_data = req_id;                                                  // see R03, R09
    end else if (k_q == bbp_pkg::IN_LAST) begin
      case (mode_q)
        bbp_pkg::MODE_CFG: push_data = bbp_pkg::CFG_TAG;                   // see R11
        bbp_pkg::MODE_CMD: push_data = bbp_pkg::CMD_TAG;
        default:           push_data = 16'(rd_idx_q);                      // see R05
      endcase
    end else if (mode_q == bbp_pkg::MODE_CFG) begin
      if (k_q == bbp_pkg::W_CFG_MOD) begin
        push_data = err_mod_q;                                             // see R11
      end else if (k_q == bbp_pkg::W_CFG_P1) begin
        push_data = err_p1_q;
      end else if (k_q == bbp_pkg::W_CFG_P2) begin
        push_data = err_p2_q;
      end
    end else if (mode_q == bbp_pkg::MODE_NORM) begin
      if (k_q >= bbp_pkg::W_RD_FIRST && k_q <= bbp_pkg::W_RD_LAST) begin
        push_data = i_db_rdata;                                            // see R03
      end else if (k_q == bbp_pkg::W_SCAN) begin
        push_data = scan_q;                                                // see R04, R06
      end else if (k_q > bbp_pkg::W_SCAN && k_q < bbp_pkg::W_PERR_FIRST) begin
        case (k_q - bbp_pkg::W_ID_FIRST)
          8'h00:   push_data = PRODUCT_CODE[15:0];
          8'h01:   push_data = PRODUCT_CODE[31:16];
          8'h02:   push_data = PRODUCT_VER[15:0];
          8'h03:   push_data = PRODUCT_VER[31:16];
          8'h04:   push_data = OS_CODE[15:0];
          8'h05:   push_data = OS_CODE[31:16];
          8'h06:   push_data = RUN_NUMBER[15:0];
          default: push_data = RUN_NUMBER[31:16];
        endcase
      end else if (k_q >= bbp_pkg::W_XFER_FIRST && k_q <= bbp_pkg::W_XFER_LAST) begin
        push_data = xfer_q[3'(k_q - bbp_pkg::W_XFER_FIRST)];               // see R05
      end else if (k_q >= bbp_pkg::W_PERR_FIRST && k_q <= bbp_pkg::W_LERR_LAST) begin
        push_data = i_db_rdata;                                            // see R04, R05
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  // restarts wait for an image boundary so the host never sees a cut image
  assign take_restart = rst_pend_q &&
                        ((state_q == bbp_pkg::ST_HOLD) ||
                         (state_q == bbp_pkg::ST_SEND && k_q == '0 &&
                          ph_q == bbp_pkg::PH_ADDR));

  always_comb begin
    state_d    = state_q;
    mode_d     = mode_q;
    k_d        = k_q;
    ph_d       = ph_q;
    rd_idx_d   = rd_idx_q;
    wr_idx_d   = wr_idx_q;
    nrd_d      = nrd_q;
    nwr_d      = nwr_q;
    blk_d      = blk_q;
    rx_id_d    = rx_id_q;
    rx_ok_d    = rx_ok_q;
    err_mod_d  = err_mod_q;
    err_p1_d   = err_p1_q;
    err_p2_d   = err_p2_q;
    scan_d     = scan_q;
    xfer_d     = xfer_q;
    db_addr_d  = db_addr_q;
    db_we_d    = 1'b0;
    db_wdata_d = db_wdata_q;
    push_valid = 1'b0;
    rst_pend_d = i_restart | (rst_pend_q & ~take_restart);

    case (state_q)
      bbp_pkg::ST_SEND: begin
        case (ph_q)
          bbp_pkg::PH_ADDR: begin
            if (k_q >= bbp_pkg::W_PERR_FIRST) begin
              db_addr_d = bbp_pkg::DB_STAT_BASE + 13'(k_q - bbp_pkg::W_PERR_FIRST);
            end else begin
              db_addr_d = rd_base + 13'(k_q - bbp_pkg::W_RD_FIRST);        // see R16
            end
            ph_d = bbp_pkg::PH_WAIT;
          end
          bbp_pkg::PH_WAIT: begin
            ph_d = bbp_pkg::PH_PUSH;
          end
          bbp_pkg::PH_PUSH: begin
            push_valid = 1'b1;
            if (push_ready) begin
              ph_d = bbp_pkg::PH_ADDR;
              if (k_q == bbp_pkg::IN_LAST) begin                           // see R17
                k_d     = '0;
                state_d = bbp_pkg::ST_RECV;
                scan_d  = scan_q + 16'h0001;
                case (mode_q)
                  bbp_pkg::MODE_CFG: xfer_d[bbp_pkg::XF_CFG] = xfer_q[bbp_pkg::XF_CFG] + 16'h0001;
                  bbp_pkg::MODE_CMD: xfer_d[bbp_pkg::XF_CMD] = xfer_q[bbp_pkg::XF_CMD] + 16'h0001;
                  default:           xfer_d[bbp_pkg::XF_RD]  = xfer_q[bbp_pkg::XF_RD] + 16'h0001;
                endcase
              end else begin
                k_d = k_q + 8'h01;
              end
            end
          end
          default: begin
            ph_d = bbp_pkg::PH_ADDR;
          end
        endcase
      end

      bbp_pkg::ST_RECV: begin
        if (i_out_valid) begin
          if (k_q == bbp_pkg::O_ID) begin
            rx_id_d = i_out_data;                                          // see R01
            case (mode_q)
              bbp_pkg::MODE_NORM: rx_ok_d = (i_out_data <= bbp_pkg::MAX_INDEX); // see R18
              default:            rx_ok_d = (i_out_data == req_id);        // see R10, R15
            endcase
          end else if (rx_ok_q && k_q <= bbp_pkg::O_PAY_LAST) begin
            db_we_d    = 1'b1;                                             // see R02
            db_addr_d  = rx_base + 13'(k_q - bbp_pkg::O_PAY_FIRST);
            db_wdata_d = i_out_data;
          end
          if (rx_ok_q && mode_q == bbp_pkg::MODE_CFG) begin                // see R12
            if (k_q == bbp_pkg::O_CFG_RCNT) begin
              nrd_d = i_out_data[4:0];
              err_mod_d[bbp_pkg::ERR_RCNT] = (i_out_data == 16'h0000) ||
                                             (i_out_data > bbp_pkg::MAX_INDEX);
            end
            if (k_q == bbp_pkg::O_CFG_WCNT) begin
              nwr_d = i_out_data[4:0];
              err_mod_d[bbp_pkg::ERR_WCNT] = (i_out_data == 16'h0000) ||
                                             (i_out_data > bbp_pkg::MAX_INDEX);
            end
            if (k_q == bbp_pkg::O_CFG_P1_TYP) begin
              err_p1_d[bbp_pkg::ERR_PTYPE] = (i_out_data > bbp_pkg::PORT_TYPE_MAX);
            end
            if (k_q == bbp_pkg::O_CFG_P2_TYP) begin
              err_p2_d[bbp_pkg::ERR_PTYPE] = (i_out_data > bbp_pkg::PORT_TYPE_MAX);
            end
          end
          if (k_q == bbp_pkg::OUT_LAST) begin                              // see R17
            k_d     = '0;
            state_d = bbp_pkg::ST_SEND;
            case (mode_q)
              bbp_pkg::MODE_CFG: begin
                // stays in configuration until a clean 9000 block arrives
                if (rx_ok_q && (err_mod_d | err_p1_d | err_p2_d) == 16'h0000) begin // see R12
                  mode_d = bbp_pkg::MODE_CMD;
                  blk_d  = '0;
                end
              end
              bbp_pkg::MODE_CMD: begin
                if (rx_ok_q) begin                                         // see R14
                  if (blk_q == bbp_pkg::CMD_BLK_LAST) begin
                    mode_d   = bbp_pkg::MODE_NORM;
                    rd_idx_d = bbp_pkg::FIRST_INDEX;
                    wr_idx_d = bbp_pkg::FIRST_INDEX;
                  end else begin
                    blk_d = blk_q + 3'h1;
                  end
                end
              end
              default: begin
                rd_idx_d = (rd_idx_q >= nrd_q) ? bbp_pkg::FIRST_INDEX
                                               : rd_idx_q + 5'h01;         // see R07
                if (rx_ok_q && rx_id_q == 16'(wr_idx_q)) begin
                  wr_idx_d = (wr_idx_q >= nwr_q) ? bbp_pkg::FIRST_INDEX
                                                 : wr_idx_q + 5'h01;       // see R07
                  xfer_d[bbp_pkg::XF_WR] = xfer_q[bbp_pkg::XF_WR] + 16'h0001;
                end else if (rx_ok_q) begin
                  // foreign index stored; write request repeats
                  xfer_d[bbp_pkg::XF_OOS] = xfer_q[bbp_pkg::XF_OOS] + 16'h0001; // see R08
                end else begin
                  xfer_d[bbp_pkg::XF_REJ] = xfer_q[bbp_pkg::XF_REJ] + 16'h0001; // see R18
                end
              end
            endcase
            if (mode_d == bbp_pkg::MODE_NORM && (i_net_cmd_req || i_dbg_req)) begin
              state_d = bbp_pkg::ST_HOLD;                                  // see R08
            end
          end else begin
            k_d = k_q + 8'h01;
          end
        end
      end

      bbp_pkg::ST_HOLD: begin
        if (!i_net_cmd_req && !i_dbg_req) begin
          state_d = bbp_pkg::ST_SEND;                                      // see R08
        end
      end

      default: begin
        state_d = bbp_pkg::ST_SEND;
      end
    endcase

    if (take_restart) begin                                                // see R09
      state_d  = bbp_pkg::ST_SEND;
      mode_d   = bbp_pkg::MODE_CFG;
      k_d      = '0;
      ph_d     = bbp_pkg::PH_ADDR;
      blk_d    = '0;
      rd_idx_d = bbp_pkg::FIRST_INDEX;
      wr_idx_d = bbp_pkg::FIRST_INDEX;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= bbp_pkg::ST_SEND;
      mode_q     <= bbp_pkg::MODE_CFG;                                     // see R09
      k_q        <= '0;
      ph_q       <= bbp_pkg::PH_ADDR;
      rd_idx_q   <= bbp_pkg::FIRST_INDEX;
      wr_idx_q   <= bbp_pkg::FIRST_INDEX;
      nrd_q      <= bbp_pkg::FIRST_INDEX;
      nwr_q      <= bbp_pkg::FIRST_INDEX;
      blk_q      <= '0;
      rx_id_q    <= '0;
      rx_ok_q    <= 1'b0;
      err_mod_q  <= '0;
      err_p1_q   <= '0;
      err_p2_q   <= '0;
      scan_q     <= '0;
      for (int i = 0; i < bbp_pkg::XF_N; i++) begin
        xfer_q[i] <= '0;
      end
      rst_pend_q <= 1'b0;
      db_addr_q  <= '0;
      db_we_q    <= 1'b0;
      db_wdata_q <= '0;
    end else begin
      state_q    <= state_d;
      mode_q     <= mode_d;
      k_q        <= k_d;
      ph_q       <= ph_d;
      rd_idx_q   <= rd_idx_d;
      wr_idx_q   <= wr_idx_d;
      nrd_q      <= nrd_d;
      nwr_q      <= nwr_d;
      blk_q      <= blk_d;
      rx_id_q    <= rx_id_d;
      rx_ok_q    <= rx_ok_d;
      err_mod_q  <= err_mod_d;
      err_p1_q   <= err_p1_d;
      err_p2_q   <= err_p2_d;
      scan_q     <= scan_d;
      xfer_q     <= xfer_d;
      rst_pend_q <= rst_pend_d;
      db_addr_q  <= db_addr_d;
      db_we_q    <= db_we_d;
      db_wdata_q <= db_wdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input image buffer; a stalled host holds the word sequencer

  bbp_fifo #(
    .WIDTH (bbp_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_in_fifo (
    .i_clk      (i_clk_sys),
    .i_rst_n    (rst_n),
    .i_wr_valid (push_valid),
    .o_wr_ready (push_ready),
    .i_wr_data  (push_data),
    .o_rd_valid (o_in_valid),
    .i_rd_ready (i_in_ready),
    .o_rd_data  (o_in_data)
  );

endmodule : bbp_pager

// *** bbp_checker.sv ***
// port assertions for the block pager
`timescale 1ns/100ps
module bbp_checker (
  input wire logic        i_clk_sys, i_reset_n, i_out_valid, o_out_ready,
  input wire logic        o_in_valid, i_in_ready, o_db_we, o_cfg_fault,
  input wire logic [15:0] i_out_data, o_in_data, o_db_wdata,
  input wire logic [12:0] o_db_addr,
  input wire logic [1:0]  o_mode
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_reset_quiet: assert property (disable iff (1'b0)
    !i_reset_n |-> !o_in_valid && !o_db_we && o_mode == 2'h0) else $error("busy in reset");
  a_in_hold: assert property (o_in_valid && !i_in_ready |=> o_in_valid && $stable(o_in_data))
    else $error("word lost");
  a_we_cause: assert property (o_db_we |-> $past(i_out_valid && o_out_ready))
    else $error("write without word");
  a_wdata_copy: assert property (o_db_we |-> o_db_wdata == $past(i_out_data))
    else $error("bad write data");
  a_addr_step: assert property (o_db_we && $past(o_db_we) |-> o_db_addr == $past(o_db_addr) + 13'h1)
    else $error("address skipped");
  a_norm_user: assert property (o_mode == 2'h2 && o_db_we |-> o_db_addr < 13'h1388)
    else $error("write outside user area");
  a_norm_clean: assert property (o_mode == 2'h2 |-> !o_cfg_fault)
    else $error("running with fault");
  a_norm_entry: assert property ($changed(o_mode) && o_mode == 2'h2 |-> $past(o_mode) == 2'h1)
    else $error("lists skipped");
  c_norm_write: cover property (o_mode == 2'h2 && o_db_we);
  c_stall: cover property (o_in_valid && !i_in_ready);
  c_fault: cover property (o_cfg_fault);
endmodule : bbp_checker
bind bbp_pager bbp_checker u_chk (.*);

// *** bbp_db_model.sv ***
// word database model: synchronous read
`timescale 1ns/100ps
module bbp_db_model (
  input  wire logic        i_clk,
  input  wire logic [12:0] i_addr,
  input  wire logic        i_we,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata
);
  logic [15:0] mem [0:6999];
  logic [12:0] addr_q;
  always_ff @(posedge i_clk) begin
    if (i_we) mem[i_addr] <= i_wdata;
    addr_q <= i_addr;
  end
  // unwritten words read unknown, no kinder than real memory
  assign o_rdata = mem[addr_q];
endmodule : bbp_db_model

// *** testbench.sv ***
// bench acting as host for the block pager
`timescale 1ns/100ps
module testbench;
  logic        i_clk_sys, i_reset_n, i_restart, i_net_cmd_req, i_dbg_req, bad;
  logic        i_out_valid, o_out_ready, o_in_valid, i_in_ready, o_db_we, o_cfg_fault;
  logic [15:0] i_out_data, o_in_data, o_db_wdata, i_db_rdata, img [0:249];
  logic [12:0] o_db_addr;
  logic [1:0]  o_mode;
  int          fails, n_tests, sc;
  // {requested write index, read index}
  logic [31:0] rows [0:15] = '{32'h2328fffe, 32'h1770fffd, 32'h1771fffd, 32'h1772fffd,
    32'h1773fffd, 32'h17d4fffd, 32'h17d5fffd, 32'h17d6fffd, 32'h17d7fffd, 32'h00010001,
    32'h00020002, 32'h00010003, 32'h00020001, 32'h00010002, 32'h00020003, 32'h00010001};
  bbp_pager DUT (.*);
  bbp_db_model ram (.i_clk(i_clk_sys), .i_addr(o_db_addr), .i_we(o_db_we),
    .i_wdata(o_db_wdata), .o_rdata(i_db_rdata));
  initial begin
    i_clk_sys = 0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  //////////////////////////////////////////////////
  task chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task get_img;
    int k, t;
    k = 0;
    t = 0;
    while (k < 250) begin
      @(posedge i_clk_sys);
      if (o_in_valid && i_in_ready) img[k++] = o_in_data;
      t++;
      #1 i_in_ready = (t % 5 != 0); // every fifth cycle stalls the host
    end
  endtask : get_img
  function logic [15:0] pat(input logic [15:0] idx, input int k);
    if (k == 0) return idx;
    if (idx == 16'h2328) return k == 1 ? (bad ? 16'h0 : 16'h3) : k == 2 ? 16'h2 : 16'h0;
    return {idx[7:0], 8'(k)};
  endfunction : pat
  task put_img(input logic [15:0] idx);
    for (int k = 0; k < 248; k++) begin
      i_out_valid = 1;
      i_out_data = pat(idx, k);
      do @(posedge i_clk_sys); while (!o_out_ready);
      #1;
    end
    i_out_valid = 0;
  endtask : put_img
  //////////////////////////////////////////////////
  initial begin
    {i_reset_n, i_restart, i_net_cmd_req, i_dbg_req, i_out_valid, i_in_ready, bad} = 0;
    i_out_data = 0;
    repeat (20) @(posedge i_clk_sys);
    #1 i_reset_n = 1;
    for (int i = 0; i < 16; i++) begin
      get_img;
      chk(img[1], rows[i][31:16]);
      chk(img[249], rows[i][15:0]);
      if (i == 9) chk(16'(o_mode), 16'h2);
      if (i > 9) chk(img[202], 16'(sc + 1));
      sc = img[202];
      if (i > 11 && i < 14) chk(img[201], {img[249][7:0], 8'hc8});
      put_img(rows[i][31:16]);
    end
    get_img;
    put_img(16'd25);
    get_img;
    chk(img[228], 16'h1);
    put_img(16'h0);
    get_img;
    chk(img[227], 16'h1);
    chk(img[1], 16'h2);
    {i_dbg_req, i_in_ready} = 2'b10; // stalled host, while the debug request holds the next image back
    put_img(16'h2);
    repeat (300) @(posedge i_clk_sys);
    chk(16'(o_in_valid), 16'h0);
    #1 {i_dbg_req, i_net_cmd_req} = 2'b01;
    repeat (300) @(posedge i_clk_sys);
    chk(16'(o_in_valid), 16'h0);
    #1 i_restart = 1;
    repeat (2) @(posedge i_clk_sys);
    #1 {i_restart, i_net_cmd_req} = 0;
    get_img;
    if (img[1] !== 16'h2328) begin
      put_img(img[1]);
      get_img;
    end
    chk(img[1], 16'h2328);
    bad = 1;
    put_img(16'h2328);
    get_img;
    chk(img[2], 16'h1);
    chk(16'(o_cfg_fault), 16'h1);
    end_sim;
  end
  initial begin
    #6000000 fails++;
    end_sim;
  end
endmodule : testbench
